// file: hdl/acx_aux_ctrl.sv
// Auxiliary control: software reset, dual data pointers, signature and customer bytes,
// and power-up configuration capture and read-back.
// Assumes the CPU core, SFR strobes and code memory all run on i_clk.
//
// Functional notes
// RL1: Writing one to software reset bit resets all SFRs, restarts fetch at zero.
// RL2: Software must avoid setting the software reset bit by accident.
// RL3: Two data pointers; select bit picks one, the other stays hidden.
// RL4: High and low byte reads and writes act on the selected pointer.
// RL5: Pointer increment adds one to the selected sixteen-bit pointer.
// RL6: Immediate load fills the selected pointer, other pointer unchanged.
// RL7: Indexed jump and code read address is accumulator plus selected pointer.
// RL8: Bit two of auxiliary control reads zero, ignores writes.
// RL9: External data space reads go to configuration information, not pins.
// RL10: Three signature bytes returned by code reads at their fixed addresses.
// RL11: Thirty-two byte customer area readable as data, never as instructions.
// RL12: Configuration fixed at power up; program may only read it.
// RL13: Configuration byte one read at its external address; unprogrammed reads all ones.
// RL14: Reset pin disable turns the reset pin into an input-only port pin.
// RL15: Undefined oscillator codes are reserved and select no mode; the decoder gives ACX_OSC_EXT with osc_valid low.
// RL16: External programmer talks serially on two pins in programming mode.
// RL17: Config byte bits: watchdog, reset pin, port level, brownout, clock, oscillator.
// RL18: Oscillator codes: 111 external, 011 RC, 010 low, 001 medium, 000 high.
// RL19: Port pins leave reset high when port level bit one, else low.
`timescale 1ns/1ps
module acx_aux_ctrl #(
	parameter logic [7:0] SIG_BYTE0 = 8'h5A, // Arbitrary value
	parameter logic [7:0] SIG_BYTE1 = 8'hA5, // Arbitrary value
	parameter logic [7:0] SIG_BYTE2 = 8'h3C // Arbitrary value
) (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_aux_wr,
	input wire logic [7:0] i_aux_wdata,
	output logic [7:0] o_aux_rdata,
	input wire logic i_dph_wr,
	input wire logic i_dpl_wr,
	input wire logic [7:0] i_dp_wdata,
	output logic [7:0] o_pointer_high_byte,
	output logic [7:0] o_pointer_low_byte,
	input wire logic i_dp_inc,
	input wire logic i_dp_load,
	input wire logic [15:0] i_dp_load_val,
	input wire logic [7:0] i_acc,
	output logic [15:0] o_index_addr,
	input wire logic i_code_rd,
	input wire logic [7:0] i_code_mem_data,
	output logic [7:0] o_code_rdata,
	output logic o_code_rvalid,
	input wire logic [15:0] i_fetch_addr,
	output logic o_fetch_illegal,
	input wire logic i_ext_rd,
	output logic [7:0] o_ext_rdata,
	output logic o_ext_rvalid,
	input wire logic i_cust_prog_wr,
	input wire logic [4:0] i_cust_prog_addr,
	input wire logic [7:0] i_cust_prog_data,
	input wire logic [7:0] i_cfg_fuse,
	input wire logic i_rst_pin_b,
	output logic o_ext_reset,
	output logic o_port_pin_in,
	output logic o_sw_reset,
	output logic o_pc_restart,
	output logic o_cfg_ready,
	output acx_pkg::acx_cfg_t o_cfg,
	output logic o_port_reset_high
);
	import acx_pkg::*;

	logic [7:0] aux_store;
	logic ptr_sel;
	logic [15:0] data_pointer [2];
	logic sw_reset_q;
	logic [7:0] cfg_byte;
	acx_cap_t cap_state;
	acx_cap_t next_cap_state;
	logic [7:0] fuse_s1, fuse_s2;
	logic pin_s1, pin_s2;
	logic [7:0] cust_mem [CUST_DEPTH];

	// Software reset request and SFR clear condition
	wire logic sw_reset_hit = i_aux_wr & i_aux_wdata[AUX_SW_RESET_BIT]; // RL1

	// Selected pointer view; the other one is never routed out
	wire logic [15:0] dp_sel = data_pointer[ptr_sel]; // RL3
	assign o_pointer_high_byte = dp_sel[15:8]; // RL4
	assign o_pointer_low_byte = dp_sel[7:0]; // RL4
	assign o_index_addr = dp_sel + {8'h00, i_acc}; // RL7

	// Auxiliary control read: software reset and bits two and one read zero
	assign o_aux_rdata = {aux_store[7:4], 1'b0, 1'b0, 1'b0, ptr_sel}; // RL8

	// Auxiliary control register
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			aux_store <= AUX_RESET[7:0];
			ptr_sel <= 1'b0;
		end else if (sw_reset_hit) begin
			aux_store <= AUX_RESET[7:0]; // RL1
			ptr_sel <= 1'b0; // RL1
		end else if (i_aux_wr) begin
			aux_store <= i_aux_wdata & AUX_STORE_MASK; // RL8
			ptr_sel <= i_aux_wdata[AUX_PTR_SEL_BIT]; // RL3
		end
	end

	// Per-pointer update: load beats increment beats byte writes
	for (genvar g = 0; g < 2; g++) begin : g_dp
		wire logic mine = (ptr_sel == 1'(g));
		always_ff @(posedge i_clk or negedge i_rst_b) begin
			if (!i_rst_b) begin
				data_pointer[g] <= DP_RESET;
			end else if (sw_reset_hit) begin
				data_pointer[g] <= DP_RESET; // RL1
			end else if (mine & i_dp_load) begin
				data_pointer[g] <= i_dp_load_val; // RL6
			end else if (mine & i_dp_inc) begin
				data_pointer[g] <= data_pointer[g] + 16'h0001; // RL5
			end else if (mine & (i_dph_wr | i_dpl_wr)) begin
				data_pointer[g][15:8] <= i_dph_wr ? i_dp_wdata : data_pointer[g][15:8]; // RL4
				data_pointer[g][7:0] <= i_dpl_wr ? i_dp_wdata : data_pointer[g][7:0]; // RL4
			end
		end
	end

	// Software reset pulse, one cycle after the write
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			sw_reset_q <= 1'b0;
		end else begin
			sw_reset_q <= sw_reset_hit; // RL1
		end
	end
	assign o_sw_reset = sw_reset_q;
	assign o_pc_restart = sw_reset_q | o_ext_reset; // RL1

	// Customer area storage, written only by the programming path
	always_ff @(posedge i_clk) begin
		if (i_cust_prog_wr) begin
			cust_mem[i_cust_prog_addr] <= i_cust_prog_data;
		end
	end

	// Code-space read decode
	wire logic [15:0] code_addr = o_index_addr; // RL7
	wire logic in_cust = (code_addr >= CUST_FIRST) && (code_addr <= CUST_LAST); // RL11
	wire logic [7:0] code_byte =
		(code_addr == SIG0_ADDR) ? SIG_BYTE0 : // RL10
		(code_addr == SIG1_ADDR) ? SIG_BYTE1 : // RL10
		(code_addr == SIG2_ADDR) ? SIG_BYTE2 : // RL10
		in_cust ? cust_mem[code_addr[4:0]] : i_code_mem_data; // RL11
	assign o_fetch_illegal = (i_fetch_addr >= CUST_FIRST) && (i_fetch_addr <= CUST_LAST); // RL11

	// External-space read decode: only the configuration byte answers
	wire logic [7:0] ext_byte = (dp_sel == CFG1_ADDR) ? cfg_byte : EXT_EMPTY; // RL9 RL13

	// Read data registers
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_code_rdata <= BYTE_ZERO;
			o_code_rvalid <= 1'b0;
			o_ext_rdata <= BYTE_ZERO;
			o_ext_rvalid <= 1'b0;
		end else begin
			o_code_rvalid <= i_code_rd;
			o_ext_rvalid <= i_ext_rd;
			if (i_code_rd) begin
				o_code_rdata <= code_byte; // RL10
			end
			if (i_ext_rd) begin
				o_ext_rdata <= ext_byte; // RL9
			end
		end
	end

	// Two-stage synchronisers for the fuse lines and the reset pin
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			fuse_s1 <= CFG1_UNPROG;
			fuse_s2 <= CFG1_UNPROG;
			pin_s1 <= 1'b1;
			pin_s2 <= 1'b1;
		end else begin
			fuse_s1 <= i_cfg_fuse;
			fuse_s2 <= fuse_s1;
			pin_s1 <= i_rst_pin_b;
			pin_s2 <= pin_s1;
		end
	end

	// Power-up capture sequence: wait for the synchroniser, sample once, then hold
	always_comb begin
		unique case (cap_state)
			ACX_CAP_SYNC1: next_cap_state = ACX_CAP_SYNC2;
			ACX_CAP_SYNC2: next_cap_state = ACX_CAP_SAMPLE;
			ACX_CAP_SAMPLE: next_cap_state = ACX_CAP_RUN;
			ACX_CAP_RUN: next_cap_state = ACX_CAP_RUN;
		endcase
	end

	// Configuration byte: written only while sampling, never by software
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cap_state <= ACX_CAP_SYNC1;
			cfg_byte <= CFG1_UNPROG;
		end else begin
			cap_state <= next_cap_state;
			if (cap_state == ACX_CAP_SAMPLE) begin
				cfg_byte <= fuse_s2; // RL12
			end
		end
	end
	assign o_cfg_ready = (cap_state == ACX_CAP_RUN);

	acx_cfg_decode u_decode (
		.i_cfg_byte(cfg_byte),
		.o_cfg(o_cfg)
	);

	// Shared reset pin: reset input or plain input pin
	assign o_ext_reset = ~o_cfg.reset_pin_disable & ~pin_s2; // RL14
	assign o_port_pin_in = o_cfg.reset_pin_disable & pin_s2; // RL14
	assign o_port_reset_high = o_cfg.port_reset_level; // RL19

	// Assertions
	sequence s_software_reset_bit_write;
		i_aux_wr && i_aux_wdata[AUX_SW_RESET_BIT];
	endsequence

	property p_software_reset_bit_pulse;
		@(posedge i_clk) disable iff (!i_rst_b)
		s_software_reset_bit_write |=> o_sw_reset && o_pc_restart ##1 !o_sw_reset;
	endproperty
	a_software_reset_bit_pulse: assert property (p_software_reset_bit_pulse) else $error("software reset pulse wrong"); // RL1

	property p_software_reset_bit_clear;
		@(posedge i_clk) disable iff (!i_rst_b)
		s_software_reset_bit_write |=> (o_aux_rdata == 8'h00) && (data_pointer[0] == 16'h0000) && (data_pointer[1] == 16'h0000);
	endproperty
	a_software_reset_bit_clear: assert property (p_software_reset_bit_clear) else $error("sfrs not cleared"); // RL1

	property p_bit2_zero;
		@(posedge i_clk) disable iff (!i_rst_b)
		i_aux_wr |=> !o_aux_rdata[2] && (o_aux_rdata[0] == $past(i_aux_wdata[0] && !i_aux_wdata[3]));
	endproperty
	a_bit2_zero: assert property (p_bit2_zero) else $error("aux bit two or select wrong"); // RL8

	property p_hidden;
		@(posedge i_clk) disable iff (!i_rst_b)
		(!i_aux_wr) |=> $stable(data_pointer[!ptr_sel]);
	endproperty
	a_hidden: assert property (p_hidden) else $error("unselected pointer changed"); // RL3

	property p_inc;
		@(posedge i_clk) disable iff (!i_rst_b)
		(i_dp_inc && !i_dp_load && !i_aux_wr) |=> (dp_sel == $past(dp_sel) + 16'h0001);
	endproperty
	a_inc: assert property (p_inc) else $error("pointer increment wrong"); // RL5

	property p_load;
		@(posedge i_clk) disable iff (!i_rst_b)
		(i_dp_load && !i_aux_wr) |=> (dp_sel == $past(i_dp_load_val));
	endproperty
	a_load: assert property (p_load) else $error("pointer load wrong"); // RL6

	property p_byte_wr;
		@(posedge i_clk) disable iff (!i_rst_b)
		(i_dpl_wr && !i_dp_load && !i_dp_inc && !i_aux_wr) |=>
			(o_pointer_low_byte == $past(i_dp_wdata));
	endproperty
	a_byte_wr: assert property (p_byte_wr) else $error("low byte write wrong"); // RL4

	property p_index;
		@(posedge i_clk) disable iff (!i_rst_b)
		o_index_addr == {o_pointer_high_byte, o_pointer_low_byte} + {8'h00, i_acc};
	endproperty
	a_index: assert property (p_index) else $error("indexed address wrong"); // RL7

	property p_sig;
		@(posedge i_clk) disable iff (!i_rst_b)
		(i_code_rd && o_index_addr == SIG2_ADDR) |=> o_code_rvalid && (o_code_rdata == SIG_BYTE2);
	endproperty
	a_sig: assert property (p_sig) else $error("signature byte wrong"); // RL10

	property p_cfg_read;
		@(posedge i_clk) disable iff (!i_rst_b)
		(i_ext_rd && dp_sel == CFG1_ADDR) |=> o_ext_rvalid && (o_ext_rdata == cfg_byte);
	endproperty
	a_cfg_read: assert property (p_cfg_read) else $error("config read wrong"); // RL13

	property p_cfg_fixed;
		@(posedge i_clk) disable iff (!i_rst_b)
		o_cfg_ready |=> $stable(cfg_byte) && o_cfg_ready;
	endproperty
	a_cfg_fixed: assert property (p_cfg_fixed) else $error("config changed after capture"); // RL12

	property p_rpd;
		@(posedge i_clk) disable iff (!i_rst_b)
		!cfg_byte[CFG_RPD_BIT] |-> !o_ext_reset;
	endproperty
	a_rpd: assert property (p_rpd) else $error("reset pin active while disabled"); // RL14

endmodule : acx_aux_ctrl

// file: hdl/acx_cfg_decode.sv
// Decoder for the first power-up configuration byte.
// Assumes the byte has already been captured and is stable.
`timescale 1ns/1ps
module acx_cfg_decode (
	input wire logic [7:0] i_cfg_byte,
	output acx_pkg::acx_cfg_t o_cfg
);
	import acx_pkg::*;

	wire logic [2:0] osc_code = i_cfg_byte[CFG_OSC_MSB:0];
	logic osc_ok;

	// Only five oscillator codes name a mode; others stay reserved
	always_comb begin
		unique case (osc_code)
			3'b111, 3'b011, 3'b010, 3'b001, 3'b000: osc_ok = 1'b1; // RL18
			default: osc_ok = 1'b0; // RL15
		endcase
	end

	// Field split of the byte, one driver for the whole struct
	assign o_cfg = '{
		watchdog_enable_cfg: i_cfg_byte[CFG_WDT_BIT], // RL17
		reset_pin_disable: ~i_cfg_byte[CFG_RPD_BIT], // RL17
		port_reset_level: i_cfg_byte[CFG_PRL_BIT], // RL17
		brownout_select: i_cfg_byte[CFG_BOV_BIT], // RL17
		clock_rate_select: i_cfg_byte[CFG_CLOCK_RATE_SELECT_BIT], // RL17
		oscillator_select: osc_ok ? acx_osc_t'(osc_code) : ACX_OSC_EXT, // RL15
		osc_valid: osc_ok // RL15
	};

endmodule : acx_cfg_decode

// file: hdl/acx_pkg.sv
// Shared constants and types for the auxiliary control and configuration block.
// Assumes an 8-bit CPU core on the same clock that owns the special function register bus.
package acx_pkg;

	// Auxiliary control register fields
	localparam int AUX_PTR_SEL_BIT = 0;
	localparam int AUX_ZERO_BIT = 2;
	localparam int AUX_SW_RESET_BIT = 3;
	localparam logic [7:0] AUX_RESET = 8'h00;
	localparam logic [7:0] AUX_STORE_MASK = 8'hF0;

	// Code space addresses
	localparam logic [15:0] SIG0_ADDR = 16'hFC30;
	localparam logic [15:0] SIG1_ADDR = 16'hFC31;
	localparam logic [15:0] SIG2_ADDR = 16'hFC60;
	localparam logic [15:0] CUST_FIRST = 16'hFCE0;
	localparam logic [15:0] CUST_LAST = 16'hFCFF;
	localparam int CUST_DEPTH = 32;

	// External data space: first configuration byte
	localparam logic [15:0] CFG1_ADDR = 16'hFD00;
	localparam logic [7:0] CFG1_UNPROG = 8'hFF;
	localparam logic [7:0] EXT_EMPTY = 8'hFF;

	// Configuration byte one field positions
	localparam int CFG_WDT_BIT = 7;
	localparam int CFG_RPD_BIT = 6;
	localparam int CFG_PRL_BIT = 5;
	localparam int CFG_BOV_BIT = 4;
	localparam int CFG_CLOCK_RATE_SELECT_BIT = 3;
	localparam int CFG_OSC_MSB = 2;

	localparam logic [15:0] DP_RESET = 16'h0000;
	localparam logic [7:0] BYTE_ZERO = 8'h00;

	// Oscillator modes as coded in the configuration byte
	typedef enum logic [2:0] {
		ACX_OSC_EXT = 3'b111,
		ACX_OSC_RC = 3'b011,
		ACX_OSC_LF = 3'b010,
		ACX_OSC_MF = 3'b001,
		ACX_OSC_HF = 3'b000
	} acx_osc_t;

	// Decoded configuration
	typedef struct packed {
		logic watchdog_enable_cfg;
		logic reset_pin_disable;
		logic port_reset_level;
		logic brownout_select;
		logic clock_rate_select;
		acx_osc_t oscillator_select;
		logic osc_valid;
	} acx_cfg_t;

	// Power-up capture sequence
	typedef enum logic [1:0] {
		ACX_CAP_SYNC1 = 2'b00,
		ACX_CAP_SYNC2 = 2'b01,
		ACX_CAP_SAMPLE = 2'b11,
		ACX_CAP_RUN = 2'b10
	} acx_cap_t;

endpackage : acx_pkg

// file: verif/tb.sv
// Self-checking bench for the auxiliary control and configuration block.
// Assumes the design files under hdl/ are compiled first; inputs change on falling edges.
`timescale 1ns/1ps
module tb;
	import acx_pkg::*;
	logic i_clk, i_rst_b, i_aux_wr, i_dph_wr, i_dpl_wr, i_dp_inc, i_dp_load, i_code_rd;
	logic i_ext_rd, i_cust_prog_wr, i_rst_pin_b;
	logic [7:0] i_aux_wdata, i_dp_wdata, i_acc, i_code_mem_data, i_cust_prog_data, i_cfg_fuse;
	logic [15:0] i_dp_load_val, i_fetch_addr, o_index_addr;
	logic [4:0] i_cust_prog_addr;
	logic [7:0] o_aux_rdata, o_pointer_high_byte, o_pointer_low_byte, o_code_rdata, o_ext_rdata;
	logic o_code_rvalid, o_fetch_illegal, o_ext_rvalid, o_ext_reset, o_port_pin_in;
	logic o_sw_reset, o_pc_restart, o_cfg_ready, o_port_reset_high;
	acx_cfg_t o_cfg;
	int n_fail = 0;
	int compares = 0;

	acx_aux_ctrl DUT (
		.i_clk(i_clk), .i_rst_b(i_rst_b), .i_aux_wr(i_aux_wr), .i_aux_wdata(i_aux_wdata),
		.o_aux_rdata(o_aux_rdata), .i_dph_wr(i_dph_wr), .i_dpl_wr(i_dpl_wr),
		.i_dp_wdata(i_dp_wdata), .o_pointer_high_byte(o_pointer_high_byte),
		.o_pointer_low_byte(o_pointer_low_byte), .i_dp_inc(i_dp_inc), .i_dp_load(i_dp_load),
		.i_dp_load_val(i_dp_load_val), .i_acc(i_acc), .o_index_addr(o_index_addr),
		.i_code_rd(i_code_rd), .i_code_mem_data(i_code_mem_data), .o_code_rdata(o_code_rdata),
		.o_code_rvalid(o_code_rvalid), .i_fetch_addr(i_fetch_addr),
		.o_fetch_illegal(o_fetch_illegal), .i_ext_rd(i_ext_rd), .o_ext_rdata(o_ext_rdata),
		.o_ext_rvalid(o_ext_rvalid), .i_cust_prog_wr(i_cust_prog_wr),
		.i_cust_prog_addr(i_cust_prog_addr), .i_cust_prog_data(i_cust_prog_data),
		.i_cfg_fuse(i_cfg_fuse), .i_rst_pin_b(i_rst_pin_b), .o_ext_reset(o_ext_reset),
		.o_port_pin_in(o_port_pin_in), .o_sw_reset(o_sw_reset), .o_pc_restart(o_pc_restart),
		.o_cfg_ready(o_cfg_ready), .o_cfg(o_cfg), .o_port_reset_high(o_port_reset_high)
	);

	// Free-running 100 MHz clock
	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end

	task automatic finish_test();
		$display("compares=%0d n_fail=%0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : finish_test

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// Bounded wait for a level; a lapse ends the run
	task automatic wait_hi(ref logic s, input logic lvl);
		int n;
		for (n = 0; n < 8 && s !== lvl; n++) begin
			@(negedge i_clk);
		end
		if (s !== lvl) begin
			n_fail++;
			finish_test();
		end
	endtask : wait_hi

	task automatic do_reset(input logic [7:0] fuse);
		i_cfg_fuse = fuse;
		i_rst_b = 1'b0;
		repeat (20) @(negedge i_clk);
		i_rst_b = 1'b1;
		wait_hi(o_cfg_ready, 1'b1);
	endtask : do_reset

	task automatic aux_wr(input logic [7:0] v);
		i_aux_wr = 1'b1;
		i_aux_wdata = v;
		@(negedge i_clk);
		i_aux_wr = 1'b0;
	endtask : aux_wr

	task automatic load(input logic [15:0] v);
		i_dp_load = 1'b1;
		i_dp_load_val = v;
		@(negedge i_clk);
		i_dp_load = 1'b0;
	endtask : load

	// Code read through the selected pointer plus accumulator
	task automatic code_rd(input logic [15:0] a, input logic [7:0] acc, input logic [7:0] exp);
		load(a);
		i_acc = acc;
		i_code_rd = 1'b1;
		@(negedge i_clk);
		i_code_rd = 1'b0;
		chk(o_code_rvalid, 1'b1);
		chk(o_code_rdata, exp);
		@(negedge i_clk);
		chk(o_code_rvalid, 1'b0);
	endtask : code_rd

	task automatic ext_rd(input logic [15:0] a, input logic [7:0] exp);
		load(a);
		i_ext_rd = 1'b1;
		@(negedge i_clk);
		i_ext_rd = 1'b0;
		chk(o_ext_rvalid, 1'b1);
		chk(o_ext_rdata, exp);
	endtask : ext_rd

	// Dual pointers: isolation, byte writes, increment wrap, select toggle by increment
	task automatic t_pointers();
		aux_wr(8'hF0);
		load(16'h1234);
		aux_wr(8'hF7);
		chk(o_aux_rdata, 8'hF1);
		load(16'hFFFF);
		chk({o_pointer_high_byte, o_pointer_low_byte}, 16'hFFFF);
		i_dp_inc = 1'b1;
		@(negedge i_clk);
		i_dp_inc = 1'b0;
		chk({o_pointer_high_byte, o_pointer_low_byte}, 16'h0000);
		i_dph_wr = 1'b1;
		i_dp_wdata = 8'hAB;
		@(negedge i_clk);
		i_dph_wr = 1'b0;
		i_dpl_wr = 1'b1;
		i_dp_wdata = 8'hCD;
		@(negedge i_clk);
		i_dpl_wr = 1'b0;
		i_acc = 8'h40;
		@(negedge i_clk);
		chk(o_index_addr, 16'hAC0D);
		aux_wr(o_aux_rdata + 8'h01);
		chk(o_aux_rdata, 8'hF0);
		chk({o_pointer_high_byte, o_pointer_low_byte}, 16'h1234);
		@(negedge i_clk);
		aux_wr(8'hF1);
		chk({o_pointer_high_byte, o_pointer_low_byte}, 16'hABCD);
	endtask : t_pointers

	// Signatures, customer area, main memory and fetch guard
	task automatic t_code();
		code_rd(SIG0_ADDR, 8'h00, 8'h5A);
		code_rd(16'hFC00, 8'h31, 8'hA5);
		code_rd(SIG2_ADDR, 8'h00, 8'h3C);
		i_cust_prog_wr = 1'b1;
		i_cust_prog_addr = 5'h1F;
		i_cust_prog_data = 8'hC3;
		@(negedge i_clk);
		i_cust_prog_wr = 1'b0;
		code_rd(CUST_LAST, 8'h00, 8'hC3);
		code_rd(16'h0100, 8'h02, 8'h77);
		i_fetch_addr = CUST_FIRST;
		@(negedge i_clk);
		chk(o_fetch_illegal, 1'b1);
		i_fetch_addr = 16'hFCDF;
		@(negedge i_clk);
		chk(o_fetch_illegal, 1'b0);
	endtask : t_code

	// Software reset clears pointers and control, pulses restart once
	task automatic t_swreset();
		aux_wr(8'h09);
		chk({o_pointer_high_byte, o_pointer_low_byte}, 16'h0000);
		chk(o_aux_rdata, 8'h00);
		wait_hi(o_sw_reset, 1'b1);
		chk(o_pc_restart, 1'b1);
		@(negedge i_clk);
		chk(o_sw_reset, 1'b0);
		chk(o_cfg_ready, 1'b1);
	endtask : t_swreset

	// Configuration decode, read-back and reset pin use
	task automatic t_config();
		logic [2:0] osc_codes [4] = '{3'h0, 3'h2, 3'h3, 3'h7};
		do_reset(8'hA9);
		chk(o_cfg.reset_pin_disable, 1'b1);
		chk({o_cfg.watchdog_enable_cfg, o_cfg.port_reset_level, o_cfg.brownout_select}, 3'h6);
		chk({o_cfg.clock_rate_select, o_cfg.oscillator_select, o_cfg.osc_valid}, 5'h13);
		chk(o_port_reset_high, 1'b1);
		ext_rd(CFG1_ADDR, 8'hA9);
		ext_rd(16'h0000, 8'hFF);
		i_rst_pin_b = 1'b0;
		wait_hi(o_port_pin_in, 1'b0);
		i_rst_pin_b = 1'b1;
		wait_hi(o_port_pin_in, 1'b1);
		i_rst_pin_b = 1'b0;
		repeat (4) @(negedge i_clk);
		chk(o_ext_reset, 1'b0);
		i_rst_pin_b = 1'b1;
		do_reset(8'h5C);
		chk(o_cfg.osc_valid, 1'b0);
		chk(o_port_reset_high, 1'b0);
		chk(o_cfg.reset_pin_disable, 1'b0);
		i_cfg_fuse = 8'hFF;
		repeat (4) @(negedge i_clk);
		ext_rd(CFG1_ADDR, 8'h5C);
		i_rst_pin_b = 1'b0;
		wait_hi(o_ext_reset, 1'b1);
		chk(o_pc_restart, 1'b1);
		chk(o_port_pin_in, 1'b0);
		i_rst_pin_b = 1'b1;
		// Four of the five defined oscillator codes (all but 001) decode to themselves and are valid
		for (int k = 0; k < 4; k++) begin
			do_reset({5'h1F, osc_codes[k]});
			chk({o_cfg.oscillator_select, o_cfg.osc_valid}, {osc_codes[k], 1'b1});
		end
	endtask : t_config

	// Main sequence
	initial begin
		{i_aux_wr, i_dph_wr, i_dpl_wr, i_dp_inc, i_dp_load, i_code_rd, i_ext_rd} = 7'h00;
		i_cust_prog_wr = 1'b0;
		i_rst_pin_b = 1'b1;
		{i_aux_wdata, i_dp_wdata, i_acc, i_cust_prog_data} = 32'h0;
		i_code_mem_data = 8'h77;
		i_dp_load_val = 16'h0000;
		i_fetch_addr = 16'h0000;
		i_cust_prog_addr = 5'h00;
		i_rst_b = 1'b0;
		do_reset(8'hFF);
		chk(o_aux_rdata, 8'h00);
		ext_rd(CFG1_ADDR, 8'hFF);
		t_pointers();
		t_code();
		t_swreset();
		t_config();
		finish_test();
	end
endmodule : tb
